//--- tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import vsd_pkg::*;

	localparam logic [31:0] FLIP [5] = '{32'h0, 32'h80000000,
		32'h00040000, 32'hff000000, 32'h00800000};
	localparam logic [4:0] MODE24 = 5'b11000;
	localparam logic [4:0] SEL_EXP = 5'b01001;
	localparam vsd_owner_type PRIO [4] = '{OWN_ETH, OWN_SCSI, OWN_ETH,
		OWN_VME};

	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] lo_sw = 8'h00;
	logic [7:0] hi_sw = 8'h00;
	logic vme_as, vme_iack, vme_write, vme_oe_b, vme_dtack, dtack_q;
	logic [2:0] vme_lvl;
	logic [31:0] vme_addr;
	logic [31:0] base = 32'h00000000;
	logic eop, send, eth_rst, eth_ca, eth_lb;
	logic [15:0] dma_m;
	int ca_n = 0;
	int eop_n = 0;
	logic [15:0] vme_wd, vme_rd, rd, csr, wd, mem_rdata = 16'h0000;
	logic irq2, irq3, scsi_rst_b, eth_ack, scsi_ack, ok;
	logic eth_req = 1'b0;
	logic byte_req = 1'b0;
	logic scsi_irq = 1'b0;
	logic eth_irq = 1'b0;
	logic [16:0] eth_off = 17'h00000;
	logic [15:0] eth_wd = 16'h0000;
	logic [7:0] scsi_wd = 8'h00;
	logic [7:0] vec2_m, vec3_m;
	logic [17:0] off;
	vsd_cycle_type o_cycle, last_vme;
	vsd_owner_type order_q [$];
	int fail_count = 0;
	int tests_run = 0;
	int k;
	integer seed = 32'h8f91;

	initial begin
		forever #25 i_sys_clk = ~i_sys_clk;
	end

	vsd_host_bfm u_host (.i_sys_clk(i_sys_clk), .i_vme_dtack(vme_dtack),
		.i_vme_data(vme_rd), .o_vme_as(vme_as), .o_vme_iack(vme_iack),
		.o_vme_iack_level(vme_lvl), .o_vme_write(vme_write),
		.o_vme_addr(vme_addr), .o_vme_data(vme_wd));

	vsd_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_low_address_switch_pack(lo_sw),
		.i_high_address_switch_pack(hi_sw), .i_vme_as(vme_as),
		.i_vme_iack(vme_iack), .i_vme_iack_level(vme_lvl),
		.i_vme_write(vme_write), .i_vme_addr(vme_addr),
		.i_vme_data(vme_wd), .o_vme_data(vme_rd),
		.o_vme_data_oe_b(vme_oe_b), .o_vme_dtack(vme_dtack),
		.o_vme_irq2(irq2), .o_vme_irq3(irq3), .i_eth_dma_req(eth_req),
		.i_eth_dma_write(1'b1), .i_eth_dma_offset(eth_off),
		.i_eth_dma_wdata(eth_wd), .o_eth_dma_ack(eth_ack),
		.i_byte_transfer_request(byte_req), .i_scsi_dma_wdata(scsi_wd),
		.o_scsi_dma_ack(scsi_ack), .o_scsi_eop(eop),
		.i_scsi_controller_window_chip_irq(scsi_irq),
		.i_ethernet_link_controller_chip_irq(eth_irq),
		.o_scsi_chip_reset_b(scsi_rst_b), .o_scsi_send(send),
		.o_eth_chip_reset(eth_rst), .o_eth_channel_attention(eth_ca),
		.o_eth_loopback(eth_lb), .o_cycle(o_cycle),
		.i_mem_rdata(mem_rdata));

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [17:0] a,
		input logic [15:0] d);
		u_host.access(1'b0, 3'h0, wr, base | {14'h0, a}, d,
			2'($random(seed)), rd, ok);
	endtask

	task automatic settle();
		repeat (3) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************
	// Cycle order monitor
	// ****************************************
	always @(posedge i_sys_clk) begin
		if (o_cycle.owner === OWN_VME)
			last_vme <= o_cycle;
		if (eth_ack === 1'b1) begin
			order_q.push_back(OWN_ETH);
			chk(o_cycle.addr, {1'b1, eth_off});
		end
		if (scsi_ack === 1'b1) begin
			order_q.push_back(OWN_SCSI);
			chk(o_cycle.addr, {2'b00, dma_m});
		end
		if (vme_dtack === 1'b1 && dtack_q === 1'b0) begin
			order_q.push_back(OWN_VME);
			chk({17'h0, vme_oe_b}, {17'h0, vme_write});
		end
		if (eth_ca === 1'b1)
			ca_n++;
		if (eop === 1'b1)
			eop_n++;
		chk({17'h0, eth_ack & scsi_ack}, 18'h0);
		dtack_q <= vme_dtack;
	end

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		conclude();
	end

	initial begin
		repeat (12) @(posedge i_sys_clk);
		chk({14'h0, vme_dtack, vme_oe_b, irq2 | irq3, scsi_rst_b}, 18'h4);
		#1;
		i_rst_b = 1'b1;
		// Vectors first, before any interrupt
		vec2_m = 8'($random(seed));
		vec3_m = 8'($random(seed));
		bus(1'b1, OFF_VEC2, {8'h00, vec2_m});
		bus(1'b1, OFF_VEC3, {8'h00, vec3_m});
		bus(1'b0, OFF_VEC3, 16'h0000);
		chk({1'b0, ok, rd}, {2'b01, 8'h00, vec3_m});
		bus(1'b0, 18'h10040, 16'h0000);
		chk({1'b0, ok, rd}, 18'h10000);
		for (k = 0; k < 5; k++) begin
			lo_sw = {7'($random(seed)), MODE24[k]};
			hi_sw = 8'($random(seed));
			base = {hi_sw, lo_sw[7:2], 18'h0};
			u_host.access(1'b0, 3'h0, 1'b0, (base ^ FLIP[k]) |
				{14'h0, OFF_VEC2}, 16'h0000, 2'h0, rd, ok);
			chk({1'b0, ok, rd}, SEL_EXP[k] ? {2'b01, 8'h00, vec2_m} :
				18'h0);
		end
		// Buffers and chip window
		for (k = 0; k < 6; k++) begin
			off = (k % 3 == 0) ? {2'b00, 16'($random(seed))} :
				(k % 3 == 1) ? {1'b1, 17'($random(seed))} :
				{2'b01, 13'h0, 3'($random(seed))};
			mem_rdata = 16'($random(seed));
			wd = 16'($random(seed));
			bus(k > 2, off, wd);
			chk(last_vme.addr, off);
			chk({1'b0, last_vme.write, k > 2 ? last_vme.wdata : rd},
				{1'b0, k > 2, k > 2 ? wd : mem_rdata});
		end
		// Interrupt levels and acknowledge
		bus(1'b1, OFF_SCSI_CSR, 16'h000d);
		chk({16'h0, scsi_rst_b, send}, 18'h3);
		scsi_irq = 1'b1;
		eth_irq = 1'b1;
		settle();
		chk({16'h0, irq2, irq3}, 18'h2);
		bus(1'b1, OFF_ETH_CSR, 16'hf000);
		settle();
		chk({16'h0, irq2, irq3}, 18'h3);
		chk({14'h0, eth_rst, eth_lb, 2'(ca_n)}, 18'hd);
		u_host.service(3'h2, base | {14'h0, OFF_SCSI_CSR}, rd, csr, ok);
		chk({1'b0, ok, rd}, {2'b01, 8'h00, vec2_m});
		chk({2'b00, csr}, {2'b00, SCSI_CSR_ONES | 16'h020d});
		u_host.service(3'h3, base | {14'h0, OFF_ETH_CSR}, rd, csr, ok);
		chk({1'b0, ok, rd}, {2'b01, 8'h00, vec3_m});
		chk({2'b00, csr}, 18'h0d100);
		bus(1'b1, OFF_ETH_CSR, 16'h0000);
		settle();
		chk({16'h0, irq2, irq3}, 18'h2);
		u_host.access(1'b1, 3'h3, 1'b0, base, 16'h0000, 2'h0, rd, ok);
		chk({1'b0, ok, rd}, 18'h0);
		scsi_irq = 1'b0;
		eth_irq = 1'b0;
		settle();
		chk({16'h0, irq2, irq3}, 18'h0);
		// Simultaneous sources, second word arrives mid-cycle
		eth_off = 17'($random(seed));
		eth_wd = 16'($random(seed));
		scsi_wd = 8'($random(seed));
		dma_m = 16'($random(seed));
		bus(1'b1, OFF_DMA_ADDR, dma_m);
		bus(1'b1, OFF_DMA_CNT, 16'h0001);
		order_q.delete();
		fork
			bus(1'b0, OFF_SCSI_BUF, 16'h0000);
			begin
				eth_req = 1'b1;
				byte_req = 1'b1;
				@(posedge i_sys_clk);
				#1;
				eth_req = 1'b0;
				byte_req = 1'b0;
				for (k = 0; k < 20 && o_cycle.owner !== OWN_SCSI; k++)
					@(posedge i_sys_clk);
				#1;
				eth_req = 1'b1;
				@(posedge i_sys_clk);
				#1;
				eth_req = 1'b0;
			end
		join
		settle();
		chk({14'h0, 4'(order_q.size())}, 18'h4);
		for (k = 0; k < 4; k++)
			chk({15'h0, order_q[k]}, {15'h0, PRIO[k]});
		bus(1'b0, OFF_DMA_CNT, 16'h0000);
		chk({2'b00, rd}, 18'h0);
		bus(1'b0, OFF_DMA_ADDR, 16'h0000);
		chk({2'b00, rd}, {2'b00, dma_m + 16'h0001});
		chk(18'(eop_n), 18'h1);
		conclude();
	end
endmodule
`default_nettype wire

//--- vsd_board_select.sv
`default_nettype none
module vsd_board_select import vsd_pkg::*; (
	// Switch packs, 1 = open
	input wire logic [7:0] i_low_address_switch_pack,
	input wire logic [7:0] i_high_address_switch_pack,
	// Incoming address
	input wire logic [31:18] i_addr,
	// Result
	output logic o_wide_mode,
	output logic o_board_sel
);
	logic [31:18] expect_w;
	logic [31:18] mask_w;

	// Closed mode switch selects 32-bit compare
	assign o_wide_mode = ~i_low_address_switch_pack[MODE_SW];
	// Open switch expects 1, closed expects 0
	assign expect_w = {i_high_address_switch_pack,
		i_low_address_switch_pack[7:LOW_SW_FIRST]};
	assign mask_w = o_wide_mode ? 14'h3fff : 14'h003f;
	assign o_board_sel = &(~(expect_w ^ i_addr) | ~mask_w);
endmodule
`default_nettype wire

//--- vsd_cycle_arbiter.sv
`default_nettype none
module vsd_cycle_arbiter import vsd_pkg::*; #(
	parameter int N = NUM_REQ,
	parameter int TICKS = CYCLE_TICKS
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Requests, bit 0 highest
	input wire logic i_tick,
	input wire logic [N-1:0] i_req,
	// Grant
	output logic [N-1:0] o_grant,
	output logic o_done
);
	localparam int CW = $clog2(TICKS + 1);

	function automatic logic [N-1:0] first_one(input logic [N-1:0] r);
		logic [N-1:0] g;
		g = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (r[k]) begin
				g = '0;
				g[k] = 1'b1;
			end
		end
		return g;
	endfunction

	logic [N-1:0] grant_r;
	logic [CW-1:0] cnt_r;
	logic idle_w;

	assign idle_w = ~|grant_r;
	assign o_grant = grant_r;
	assign o_done = i_tick & ~idle_w & (cnt_r == CW'(TICKS - 1));

	// One cycle at a time; new grants only when idle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			grant_r <= '0;
			cnt_r <= '0;
		end else if (i_tick) begin
			if (idle_w) begin
				grant_r <= first_one(i_req);
				cnt_r <= '0;
			end else if (o_done) begin
				grant_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	a_grant_onehot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$onehot0(grant_r)) else $error("more than one grant");
	a_top_priority: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_tick && idle_w && i_req[0] |=> grant_r[0])
		else $error("highest request not granted");
	a_hold_grant: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!idle_w && !o_done |=> $stable(grant_r))
		else $error("grant changed mid cycle");
endmodule
`default_nettype wire

//--- vsd_host_bfm.sv
`default_nettype none
module vsd_host_bfm (
	// Clock and answer
	input wire logic i_sys_clk,
	input wire logic i_vme_dtack,
	input wire logic [15:0] i_vme_data,
	// Request
	output logic o_vme_as,
	output logic o_vme_iack,
	output logic [2:0] o_vme_iack_level,
	output logic o_vme_write,
	output logic [31:0] o_vme_addr,
	output logic [15:0] o_vme_data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_vme_as = 1'b0;
		o_vme_iack = 1'b0;
		o_vme_iack_level = 3'h0;
		o_vme_write = 1'b0;
		o_vme_addr = 32'h00000000;
		o_vme_data = 16'h0000;
	end

	// ****************************************
	// One strobe, held until acknowledged or until 60 clocks pass
	// ****************************************
	task automatic access(input logic iack, input logic [2:0] lvl,
		input logic wr, input logic [31:0] a, input logic [15:0] wd,
		input logic [1:0] hold, output logic [15:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'h0000;
		@(posedge i_sys_clk);
		#1;
		o_vme_iack = iack;
		o_vme_iack_level = lvl;
		o_vme_write = wr;
		o_vme_addr = a;
		o_vme_data = wd;
		o_vme_as = 1'b1;
		for (n = 0; n < 60 && !ok; n++) begin
			@(posedge i_sys_clk);
			if (i_vme_dtack === 1'b1) begin
				ok = 1'b1;
				rd = i_vme_data;
			end
		end
		// Slow host keeps the strobe a little longer
		repeat (hold) @(posedge i_sys_clk);
		#1;
		o_vme_as = 1'b0;
		o_vme_addr = ~o_vme_addr;
		o_vme_data = ~o_vme_data;
		for (n = 0; n < 8 && i_vme_dtack !== 1'b0; n++)
			@(posedge i_sys_clk);
		@(posedge i_sys_clk);
		#1;
	endtask

	// ****************************************
	// Handler: vector, then the chip status
	// ****************************************
	task automatic service(input logic [2:0] lvl, input logic [31:0] csr_a,
		output logic [15:0] vec, output logic [15:0] csr, output logic ok);
		logic ok_a;
		access(1'b1, lvl, 1'b0, csr_a, 16'h0000, 2'h1, vec, ok_a);
		access(1'b0, 3'h0, 1'b0, csr_a, 16'h0000, 2'h0, csr, ok);
		ok = ok & ok_a;
	endtask
endmodule
`default_nettype wire

//--- vsd_pkg.sv
`default_nettype none
package vsd_pkg;
	// ****************************************
	// Clocking
	// ****************************************
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int INT_CLK_HZ = 8_000_000;
	localparam int TICK_UNIT_HZ = 1_000_000;
	localparam int TICK_STEP = INT_CLK_HZ / TICK_UNIT_HZ;
	localparam int TICK_MOD = SYS_CLK_HZ / TICK_UNIT_HZ;
	localparam int CYCLE_TICKS = 2;

	// ****************************************
	// Local offsets and spans
	// ****************************************
	localparam logic [17:0] OFF_SCSI_BUF = 18'h00000;
	localparam logic [17:0] SIZE_SCSI_BUF = 18'h10000;
	localparam logic [17:0] OFF_CHIP = 18'h10000;
	localparam logic [17:0] SIZE_CHIP = 18'h00008;
	localparam logic [17:0] OFF_DMA_ADDR = 18'h1000a;
	localparam logic [17:0] OFF_DMA_CNT = 18'h1000e;
	localparam logic [17:0] OFF_SCSI_CSR = 18'h1001a;
	localparam logic [17:0] OFF_VEC2 = 18'h1001e;
	localparam logic [17:0] OFF_ETH_CSR = 18'h1ff02;
	localparam logic [17:0] OFF_VEC3 = 18'h1ff12;
	localparam logic [17:0] OFF_ETH_BUF = 18'h20000;
	localparam logic [17:0] SIZE_ETH_BUF = 18'h20000;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int SCSI_RST_B_BIT = 0;
	localparam int SCSI_IE_BIT = 2;
	localparam int SCSI_SEND_BIT = 3;
	localparam int SCSI_IRQ_BIT = 9;
	localparam logic [15:0] SCSI_CSR_ONES = 16'h0402;
	localparam int ETH_IRQ_BIT = 8;
	localparam int ETH_IE_BIT = 12;
	localparam int ETH_CA_BIT = 13;
	localparam int ETH_LB_BIT = 14;
	localparam int ETH_RST_BIT = 15;
	localparam logic [7:0] VEC_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam int MODE_SW = 0;
	localparam int LOW_SW_FIRST = 2;
	localparam logic [2:0] LVL_SCSI = 3'h2;
	localparam logic [2:0] LVL_ETH = 3'h3;

	// ****************************************
	// Arbiter slots, highest priority first
	// ****************************************
	localparam int NUM_REQ = 4;
	localparam int REQ_ETH = 0;
	localparam int REQ_SCSI = 1;
	localparam int REQ_VME = 2;
	localparam int REQ_IACK = 3;

	typedef enum logic [2:0] {
		OWN_NONE, OWN_ETH, OWN_SCSI, OWN_VME, OWN_IACK
	} vsd_owner_type;

	typedef struct packed {
		vsd_owner_type owner;
		logic [17:0] addr;
		logic write;
		logic [15:0] wdata;
	} vsd_cycle_type;
endpackage
`default_nettype wire

//--- vsd_top.sv
`default_nettype none
module vsd_top import vsd_pkg::*; (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Address switches, 1 = open
	input wire logic [7:0] i_low_address_switch_pack,
	input wire logic [7:0] i_high_address_switch_pack,
	// Bus slave
	input wire logic i_vme_as,
	input wire logic i_vme_iack,
	input wire logic [2:0] i_vme_iack_level,
	input wire logic i_vme_write,
	input wire logic [31:0] i_vme_addr,
	input wire logic [15:0] i_vme_data,
	output logic [15:0] o_vme_data,
	output logic o_vme_data_oe_b,
	output logic o_vme_dtack,
	output logic o_vme_irq2,
	output logic o_vme_irq3,
	// DMA sources
	input wire logic i_eth_dma_req,
	input wire logic i_eth_dma_write,
	input wire logic [16:0] i_eth_dma_offset,
	input wire logic [15:0] i_eth_dma_wdata,
	output logic o_eth_dma_ack,
	input wire logic i_byte_transfer_request,
	input wire logic [7:0] i_scsi_dma_wdata,
	output logic o_scsi_dma_ack,
	output logic o_scsi_eop,
	// Chip control and status
	input wire logic i_scsi_controller_window_chip_irq,
	input wire logic i_ethernet_link_controller_chip_irq,
	output logic o_scsi_chip_reset_b,
	output logic o_scsi_send,
	output logic o_eth_chip_reset,
	output logic o_eth_channel_attention,
	output logic o_eth_loopback,
	// Buffer and chip cycle port
	output vsd_cycle_type o_cycle,
	input wire logic [15:0] i_mem_rdata
);
	// ****************************************
	// Internal 8 MHz tick
	// ****************************************
	logic [4:0] acc_r;
	logic [5:0] acc_sum_w;
	logic tick_w;

	assign acc_sum_w = {1'b0, acc_r} + 6'(TICK_STEP);
	assign tick_w = acc_sum_w >= 6'(TICK_MOD);

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc_r <= '0;
		end else begin
			acc_r <= tick_w ? 5'(acc_sum_w - 6'(TICK_MOD)) : acc_sum_w[4:0];
		end
	end

	// ****************************************
	// Board select and local decode
	// ****************************************
	logic wide_w;
	logic sel_w;
	logic [17:0] loc_w;

	vsd_board_select u_sel (
		.i_low_address_switch_pack(i_low_address_switch_pack),
		.i_high_address_switch_pack(i_high_address_switch_pack),
		.i_addr(i_vme_addr[31:18]),
		.o_wide_mode(wide_w),
		.o_board_sel(sel_w)
	);

	assign loc_w = i_vme_addr[17:0];

	function automatic logic in_span(input logic [17:0] a,
		input logic [17:0] base, input logic [17:0] size);
		logic [18:0] off;
		off = {1'b0, a} - {1'b0, base};
		return (a >= base) && (off < {1'b0, size});
	endfunction

	logic hit_mem_w;
	assign hit_mem_w = in_span(loc_w, OFF_ETH_BUF, SIZE_ETH_BUF)
		| in_span(loc_w, OFF_SCSI_BUF, SIZE_SCSI_BUF)
		| in_span(loc_w, OFF_CHIP, SIZE_CHIP);

	// ****************************************
	// Control registers
	// ****************************************
	logic scsi_rst_b_r, scsi_ie_r, scsi_send_r;
	logic eth_ie_r, eth_lb_r, eth_rst_r, eth_ca_r;
	logic [7:0] vec2_r, vec3_r;
	logic [15:0] dma_addr_r, dma_cnt_r;
	logic irq2_r, irq3_r;

	assign o_scsi_chip_reset_b = scsi_rst_b_r;
	assign o_scsi_send = scsi_send_r;
	assign o_eth_chip_reset = eth_rst_r;
	assign o_eth_loopback = eth_lb_r;
	assign o_eth_channel_attention = eth_ca_r;
	assign o_vme_irq2 = irq2_r;
	assign o_vme_irq3 = irq3_r;

	logic [15:0] scsi_csr_w, eth_csr_w, reg_rd_w;
	always_comb begin
		scsi_csr_w = SCSI_CSR_ONES;
		scsi_csr_w[SCSI_RST_B_BIT] = scsi_rst_b_r;
		scsi_csr_w[SCSI_IE_BIT] = scsi_ie_r;
		scsi_csr_w[SCSI_SEND_BIT] = scsi_send_r;
		scsi_csr_w[SCSI_IRQ_BIT] = i_scsi_controller_window_chip_irq;
		eth_csr_w = WORD_RST;
		eth_csr_w[ETH_IRQ_BIT] = i_ethernet_link_controller_chip_irq;
		eth_csr_w[ETH_IE_BIT] = eth_ie_r;
		eth_csr_w[ETH_LB_BIT] = eth_lb_r;
		eth_csr_w[ETH_RST_BIT] = eth_rst_r;
	end

	always_comb begin
		case (loc_w)
			OFF_SCSI_CSR: reg_rd_w = scsi_csr_w;
			OFF_ETH_CSR: reg_rd_w = eth_csr_w;
			OFF_DMA_ADDR: reg_rd_w = dma_addr_r;
			OFF_DMA_CNT: reg_rd_w = dma_cnt_r;
			OFF_VEC2: reg_rd_w = {8'h00, vec2_r};
			OFF_VEC3: reg_rd_w = {8'h00, vec3_r};
			default: reg_rd_w = WORD_RST;
		endcase
	end

	// ****************************************
	// Requests and arbitration
	// ****************************************
	logic eth_pend_r, scsi_pend_r, dtack_r;
	logic iack_ours_w;
	logic [NUM_REQ-1:0] req_w, grant_w;
	logic done_w;

	assign iack_ours_w = ((i_vme_iack_level == LVL_SCSI) & irq2_r)
		| ((i_vme_iack_level == LVL_ETH) & irq3_r);
	assign req_w[REQ_ETH] = eth_pend_r;
	assign req_w[REQ_SCSI] = scsi_pend_r;
	assign req_w[REQ_VME] = i_vme_as & ~i_vme_iack & sel_w & ~dtack_r;
	assign req_w[REQ_IACK] = i_vme_as & i_vme_iack & iack_ours_w & ~dtack_r;

	vsd_cycle_arbiter #(
		.N(NUM_REQ),
		.TICKS(CYCLE_TICKS)
	) u_arb (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_tick(tick_w),
		.i_req(req_w),
		.o_grant(grant_w),
		.o_done(done_w)
	);

	logic eth_done_w, scsi_done_w, vme_done_w, iack_done_w, reg_wr_w;
	assign eth_done_w = done_w & grant_w[REQ_ETH];
	assign scsi_done_w = done_w & grant_w[REQ_SCSI];
	assign vme_done_w = done_w & grant_w[REQ_VME];
	assign iack_done_w = done_w & grant_w[REQ_IACK];
	assign reg_wr_w = vme_done_w & i_vme_write & ~hit_mem_w;
	assign o_eth_dma_ack = eth_done_w;
	assign o_scsi_dma_ack = scsi_done_w;

	// Cycle port driven from the granted owner; a VME grant drives it only on buffer and chip window hits
	always_comb begin
		o_cycle = '0;
		if (grant_w[REQ_ETH]) begin
			o_cycle.owner = OWN_ETH;
			o_cycle.addr = OFF_ETH_BUF | {1'b0, i_eth_dma_offset};
			o_cycle.write = i_eth_dma_write;
			o_cycle.wdata = i_eth_dma_wdata;
		end else if (grant_w[REQ_SCSI]) begin
			o_cycle.owner = OWN_SCSI;
			o_cycle.addr = OFF_SCSI_BUF | {2'b00, dma_addr_r};
			o_cycle.write = ~scsi_send_r;
			o_cycle.wdata = {8'h00, i_scsi_dma_wdata};
		end else if (grant_w[REQ_VME] & hit_mem_w) begin
			o_cycle.owner = OWN_VME;
			o_cycle.addr = loc_w;
			o_cycle.write = i_vme_write;
			o_cycle.wdata = i_vme_data;
		end else if (grant_w[REQ_IACK]) begin
			o_cycle.owner = OWN_IACK;
		end
	end

	// ****************************************
	// Pending DMA bytes and answer path
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			eth_pend_r <= 1'b0;
			scsi_pend_r <= 1'b0;
		end else begin
			eth_pend_r <= i_eth_dma_req | (eth_pend_r & ~eth_done_w);
			scsi_pend_r <= i_byte_transfer_request
				| (scsi_pend_r & ~scsi_done_w);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dtack_r <= 1'b0;
			o_vme_data <= WORD_RST;
			o_vme_data_oe_b <= 1'b1;
		end else if (!i_vme_as) begin
			dtack_r <= 1'b0;
			o_vme_data_oe_b <= 1'b1;
		end else if (iack_done_w) begin
			dtack_r <= 1'b1;
			o_vme_data_oe_b <= 1'b0;
			o_vme_data <= {8'h00, (i_vme_iack_level == LVL_SCSI) ?
				vec2_r : vec3_r};
		end else if (vme_done_w) begin
			dtack_r <= 1'b1;
			o_vme_data_oe_b <= i_vme_write;
			o_vme_data <= hit_mem_w ? i_mem_rdata : reg_rd_w;
		end
	end
	assign o_vme_dtack = dtack_r;

	// ****************************************
	// Register writes and SCSI DMA counters
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scsi_rst_b_r <= 1'b0;
			scsi_ie_r <= 1'b0;
			scsi_send_r <= 1'b0;
			eth_ie_r <= 1'b0;
			eth_lb_r <= 1'b0;
			eth_rst_r <= 1'b0;
			eth_ca_r <= 1'b0;
			vec2_r <= VEC_RST;
			vec3_r <= VEC_RST;
			dma_addr_r <= WORD_RST;
			dma_cnt_r <= WORD_RST;
			o_scsi_eop <= 1'b0;
		end else begin
			eth_ca_r <= reg_wr_w & (loc_w == OFF_ETH_CSR)
				& i_vme_data[ETH_CA_BIT];
			o_scsi_eop <= scsi_done_w & (dma_cnt_r == 16'h0001);
			if (reg_wr_w && loc_w == OFF_SCSI_CSR) begin
				scsi_rst_b_r <= i_vme_data[SCSI_RST_B_BIT];
				scsi_ie_r <= i_vme_data[SCSI_IE_BIT];
				scsi_send_r <= i_vme_data[SCSI_SEND_BIT];
			end
			if (reg_wr_w && loc_w == OFF_ETH_CSR) begin
				eth_ie_r <= i_vme_data[ETH_IE_BIT];
				eth_lb_r <= i_vme_data[ETH_LB_BIT];
				eth_rst_r <= i_vme_data[ETH_RST_BIT];
			end
			if (reg_wr_w && loc_w == OFF_VEC2) begin
				vec2_r <= i_vme_data[7:0];
			end
			if (reg_wr_w && loc_w == OFF_VEC3) begin
				vec3_r <= i_vme_data[7:0];
			end
			if (reg_wr_w && loc_w == OFF_DMA_ADDR) begin
				dma_addr_r <= i_vme_data;
			end else if (scsi_done_w) begin
				dma_addr_r <= dma_addr_r + 16'h0001;
			end
			if (reg_wr_w && loc_w == OFF_DMA_CNT) begin
				dma_cnt_r <= i_vme_data;
			end else if (scsi_done_w) begin
				dma_cnt_r <= dma_cnt_r - 16'h0001;
			end
		end
	end

	// ****************************************
	// Interrupt levels
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq2_r <= 1'b0;
			irq3_r <= 1'b0;
		end else begin
			irq2_r <= i_scsi_controller_window_chip_irq & scsi_ie_r;
			irq3_r <= i_ethernet_link_controller_chip_irq & eth_ie_r;
		end
	end

	a_irq2_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_vme_irq2 == $past(i_scsi_controller_window_chip_irq & scsi_ie_r))
		else $error("level 2 request wrong");
	a_irq3_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_vme_irq3 == $past(i_ethernet_link_controller_chip_irq & eth_ie_r))
		else $error("level 3 request wrong");
	a_iack_vector: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		iack_done_w && i_vme_as && i_vme_iack_level == LVL_ETH |=>
		o_vme_dtack && o_vme_data[7:0] == vec3_r && !o_vme_data_oe_b)
		else $error("level 3 vector not driven");
	a_narrow_select: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!wide_w && i_vme_addr[23:18] == i_low_address_switch_pack[7:2]
		|-> sel_w) else $error("24-bit match not selected");
	a_wide_reject: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wide_w && i_vme_addr[31:24] != i_high_address_switch_pack
		|-> !sel_w) else $error("32-bit mismatch selected");
	a_tick_rate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		tick_w |=> !tick_w) else $error("tick too fast");
	a_dma_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		scsi_done_w && !reg_wr_w |=> dma_cnt_r == $past(dma_cnt_r) - 16'h0001
		&& dma_addr_r == $past(dma_addr_r) + 16'h0001)
		else $error("dma counters not stepped");
endmodule
`default_nettype wire
